// ### pkg/pwr_pkg.sv
// Constants shared by the power manager register bank and touch logic.
// Assumes a 40 MHz system clock and a register set of version 3.
package pwr_pkg;

  // Clock and lamp timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PULSE_STEP_NS = 4000000;
  localparam int unsigned FLASH_HALF_NS = 50000000;
  localparam int unsigned CNT_W = 22;

  // Register set version reported at offset zero
  localparam logic [7:0] REG_SET_VERSION = 8'h03;

  // Register offsets
  localparam logic [7:0] OFS_VERSION = 8'h00;
  localparam logic [7:0] OFS_BUS_ADDR = 8'h01;
  localparam logic [7:0] OFS_LAMP_MODE = 8'h02;
  localparam logic [7:0] OFS_CYCLES = 8'h03;
  localparam logic [7:0] OFS_THRESHOLD = 8'h04;
  localparam logic [7:0] OFS_HYSTERESIS = 8'h05;
  localparam logic [7:0] OFS_OSC_RANGE = 8'h06;
  localparam logic [7:0] OFS_OSC_MOD = 8'h07;
  localparam logic [7:0] OFS_VBAT_V1 = 8'h15;
  localparam logic [7:0] OFS_VBAT_V2 = 8'h17;
  localparam logic [7:0] OFS_VBAT_V3 = 8'h19;
  localparam logic [7:0] OFS_HIST_V1 = 8'h19;
  localparam logic [7:0] OFS_HIST_V2 = 8'h1B;
  localparam logic [7:0] OFS_HIST_V3 = 8'h1D;

  // Reset values
  localparam logic [6:0] BUS_ADDR_RST = 7'h43;
  localparam logic [7:0] LAMP_MODE_RST = 8'h01;
  localparam logic [7:0] CYCLES_RST = 8'h14;
  localparam logic [7:0] THRESHOLD_RST = 8'h0C;
  localparam logic [7:0] HYSTERESIS_RST = 8'h02;
  localparam logic [7:0] OSC_TRIM_RST = 8'h00; // Arbitrary, flash restores

  // Touch filter and press-and-hold length in samples
  localparam int unsigned BASE_SHIFT = 4;
  localparam logic [7:0] HOLD_SAMPLES = 8'h08;

  // Lamp modes
  localparam logic [7:0] LAMP_OFF = 8'h00;
  localparam logic [7:0] LAMP_ON = 8'h01;
  localparam logic [7:0] LAMP_PULSE = 8'h02;
  localparam logic [7:0] LAMP_FLASH = 8'h03;

  // Host power states
  typedef enum logic [1:0] {
    HOST_OFF = 2'b00,
    HOST_BOOT = 2'b01,
    HOST_ON = 2'b10,
    HOST_SHDN = 2'b11
  } host_state_t;

  // Bus target states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_RD_ACK = 3'b110,
    ST_SKIP = 3'b111
  } bus_state_t;

endpackage

// ### hw/pad_touch_detect.sv
// Touch decision with a filtered baseline, hysteresis and sample history.
// Assumes one sample_i pulse per finished measurement, same clock domain.
`timescale 1ns/10ps
module pad_touch_detect (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Measurement and parameters
  input wire logic sample_i,
  input wire logic [15:0] reading_i,
  input wire logic [7:0] threshold_i,
  input wire logic [7:0] hysteresis_i,
  // Decision
  output logic touched_o,
  output logic [3:0] history_o
);

  logic [15:0] base_q;
  logic primed_q;

  // Levels are 18 bits wide so the sums never wrap
  wire [17:0] rd = {2'b00, reading_i};
  wire [17:0] mid = {2'b00, base_q} + {10'h000, threshold_i};
  wire [17:0] hys = {10'h000, hysteresis_i};
  wire [17:0] on_lvl = mid + hys;
  wire [17:0] off_lvl = (mid > hys) ? mid - hys : 18'h00000;
  wire touch_d = touched_o ? !(rd < off_lvl)
                           : (rd > on_lvl);
  wire signed [16:0] diff = $signed({1'b0, reading_i})
                          - $signed({1'b0, base_q});
  wire signed [16:0] step = diff >>> pwr_pkg::BASE_SHIFT;

  // Baseline only follows while untouched, so a hold cannot drag it up
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      base_q <= 16'h0000;
      primed_q <= 1'b0;
    end else if (ce_i && sample_i) begin
      primed_q <= 1'b1;
      if (!primed_q) begin
        base_q <= reading_i;
      end else if (!touched_o) begin
        base_q <= base_q + step[15:0];
      end
    end
  end

  // Decision and history; first sample only primes the baseline
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      touched_o <= 1'b0;
      history_o <= 4'h0;
    end else if (ce_i && sample_i && primed_q) begin
      touched_o <= touch_d;
      history_o <= {history_o[2:0], touch_d};
    end
  end

  property p_touch_on;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && sample_i && primed_q && !touched_o && (rd > on_lvl)
    |=> touched_o;
  endproperty
  a_touch_on: assert property (p_touch_on)
    else $error("touch missed");

  property p_touch_off;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && sample_i && primed_q && touched_o && (rd < off_lvl)
    |=> !touched_o;
  endproperty
  a_touch_off: assert property (p_touch_off)
    else $error("release missed");

  property p_hist_shift;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && sample_i && primed_q
    |=> history_o[3:1] == $past(history_o[2:0]) && history_o[0] == touched_o;
  endproperty
  a_hist_shift: assert property (p_hist_shift)
    else $error("bad history");

endmodule

// ### hw/touch_power_i2c_regs.sv
// Register bank of the battery power manager behind an I2C target port,
// with touch pad detection, press-and-hold shutdown and lamp driver.
// Assumes SCL/SDA pins from outside the clock domain, an open-drain SDA
// resolved outside, and flash restore strobes from same-clock logic.
//
// Function
// - After power-up the target answers at 7-bit address 0x43.
// - Offset 0x01 holds the bus address, used as soon as written.
// - Offset 0x00 reads the register-set version, here 0x03.
// - Offset 0x02 picks the lamp while on: off, on, pulse, flash.
// - Host off keeps the lamp dark; booting or shutting pulses it.
// - The history byte shifts each touch sample after the first in at bit 0.
// - A long hold turns the host off; short touches are only logged.
// - Offset 0x03 gives the measure cycle count, default 20.
// - A low-pass baseline follows the average reading while untouched.
// - Touch starts above baseline plus threshold plus hysteresis.
// - Touch ends below baseline plus threshold minus hysteresis.
// - Offsets 0x06 and 0x07 are read/write oscillator trim bytes.
// - Battery voltage is a 2-byte little-endian 10-bit value.
// - The history byte sits at 0x19, 0x1B or 0x1D by version.
// - Persistent settings go to flash on change and return at power-up.
`timescale 1ns/10ps
module touch_power_i2c_regs #(
  parameter int unsigned PULSE_STEP_CYC =
    pwr_pkg::PULSE_STEP_NS / pwr_pkg::CLK_PERIOD_NS,
  parameter int unsigned FLASH_HALF_CYC =
    pwr_pkg::FLASH_HALF_NS / pwr_pkg::CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // I2C target pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Host power state, lamp and shutdown request
  input wire logic [1:0] host_state_i,
  output logic power_lamp_o,
  output logic host_off_req_o,
  // Touch measurement front end
  input wire logic pad_sample_i,
  input wire logic [15:0] pad_reading_i,
  output logic [7:0] pad_measure_cycle_count_o,
  // Battery conversion
  input wire logic [9:0] vbat_i,
  // Oscillator trims
  output logic [7:0] osc_range_trim_o,
  output logic [7:0] osc_mod_trim_o,
  // Flash restore and save
  input wire logic nvm_load_i,
  input wire logic [7:0] nvm_addr_i,
  input wire logic [7:0] nvm_data_i,
  output logic nvm_wr_o,
  output logic [7:0] nvm_addr_o,
  output logic [7:0] nvm_data_o
);

  // Battery offset for a given register-set version
  function automatic logic [7:0] vbat_ofs(input logic [7:0] ver);
    case (ver)
      8'h01: vbat_ofs = pwr_pkg::OFS_VBAT_V1;
      8'h02: vbat_ofs = pwr_pkg::OFS_VBAT_V2;
      default: vbat_ofs = pwr_pkg::OFS_VBAT_V3;
    endcase
  endfunction

  // History offset for a given register-set version
  function automatic logic [7:0] hist_ofs(input logic [7:0] ver);
    case (ver)
      8'h01: hist_ofs = pwr_pkg::OFS_HIST_V1;
      8'h02: hist_ofs = pwr_pkg::OFS_HIST_V2;
      default: hist_ofs = pwr_pkg::OFS_HIST_V3;
    endcase
  endfunction

  // Settings that are kept in flash
  function automatic logic is_persist(input logic [7:0] ofs);
    is_persist = (ofs >= pwr_pkg::OFS_BUS_ADDR)
              && (ofs <= pwr_pkg::OFS_OSC_MOD);
  endfunction

  // Pin synchronisers; stage 1 is read by stage 2 only
  logic scl_q1, scl_q2, scl_q3;
  logic sda_q1, sda_q2, sda_q3;

  // Bus target state
  pwr_pkg::bus_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic ptr_phase_q;
  logic nack_q;

  // Registers
  logic [6:0] bus_addr_q;
  logic [7:0] lamp_mode_q;
  logic [7:0] threshold_q;
  logic [7:0] hysteresis_q;
  logic [9:0] vbat_snap_q;

  // Touch and lamp state
  logic touched;
  logic [3:0] history;
  logic [7:0] hold_cnt_q;
  logic [7:0] pwm_q;
  logic [7:0] level_q;
  logic dir_q;
  logic flash_q;
  logic [pwr_pkg::CNT_W-1:0] step_cnt_q;
  logic [pwr_pkg::CNT_W-1:0] flash_cnt_q;

  // Bus events
  wire scl_rise = scl_q2 && !scl_q3;
  wire scl_fall = !scl_q2 && scl_q3;
  wire start_ev = scl_q2 && scl_q3 && sda_q3 && !sda_q2;
  wire stop_ev = scl_q2 && scl_q3 && !sda_q3 && sda_q2;
  wire byte_in = (cnt_q == 4'h8);
  wire addr_hit = (shift_q[7:1] == bus_addr_q);
  wire wr_byte = scl_fall && (st_q == pwr_pkg::ST_WR) && byte_in;
  wire rd_done = scl_fall && (st_q == pwr_pkg::ST_RD) && byte_in;
  wire bus_wr = wr_byte && !ptr_phase_q;
  // Read phase starts at the acknowledge, where the first bit is launched
  wire in_read = (st_q == pwr_pkg::ST_RD) || (st_q == pwr_pkg::ST_RD_ACK)
              || (st_q == pwr_pkg::ST_ADDR_ACK && rw_q);

  // Register write port, shared by the bus and flash restore
  wire reg_we = bus_wr || nvm_load_i;
  wire [7:0] wr_ofs = bus_wr ? ptr_q : nvm_addr_i;
  wire [7:0] wr_dat = bus_wr ? shift_q : nvm_data_i;

  // Read selection; offsets follow the reported version
  wire [7:0] vb_ofs = vbat_ofs(pwr_pkg::REG_SET_VERSION);
  wire [7:0] hs_ofs = hist_ofs(pwr_pkg::REG_SET_VERSION);
  wire [7:0] rd_byte =
    (ptr_q == pwr_pkg::OFS_VERSION) ?
      pwr_pkg::REG_SET_VERSION :
    (ptr_q == pwr_pkg::OFS_BUS_ADDR) ? {1'b0, bus_addr_q} :
    (ptr_q == pwr_pkg::OFS_LAMP_MODE) ? lamp_mode_q :
    (ptr_q == pwr_pkg::OFS_CYCLES) ? pad_measure_cycle_count_o :
    (ptr_q == pwr_pkg::OFS_THRESHOLD) ? threshold_q :
    (ptr_q == pwr_pkg::OFS_HYSTERESIS) ? hysteresis_q :
    (ptr_q == pwr_pkg::OFS_OSC_RANGE) ? osc_range_trim_o :
    (ptr_q == pwr_pkg::OFS_OSC_MOD) ? osc_mod_trim_o :
    (ptr_q == vb_ofs) ? vbat_snap_q[7:0] :
    (ptr_q == vb_ofs + 8'h01) ? {6'h00, vbat_snap_q[9:8]} :
    (ptr_q == hs_ofs) ? {4'h0, history} :
    8'h00;
  wire rd_bit = rd_byte[3'h7 - cnt_q[2:0]];

  // Synchronise the bus pins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_q1 <= 1'b1;
      scl_q2 <= 1'b1;
      scl_q3 <= 1'b1;
      sda_q1 <= 1'b1;
      sda_q2 <= 1'b1;
      sda_q3 <= 1'b1;
    end else if (ce_i) begin
      scl_q1 <= scl_i;
      scl_q2 <= scl_q1;
      scl_q3 <= scl_q2;
      sda_q1 <= sda_i;
      sda_q2 <= sda_q1;
      sda_q3 <= sda_q2;
    end
  end

  // Target sequencer; SDA only changes after an SCL fall
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= pwr_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      ptr_phase_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (start_ev) begin
        st_q <= pwr_pkg::ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_ev) begin
        st_q <= pwr_pkg::ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == pwr_pkg::ST_RD_ACK) begin
          nack_q <= sda_q2;
        end else if (!byte_in) begin
          cnt_q <= cnt_q + 4'h1;
          shift_q <= {shift_q[6:0], sda_q2};
        end
      end else if (scl_fall) begin
        case (st_q)
          pwr_pkg::ST_ADDR: begin
            if (byte_in && addr_hit) begin
              st_q <= pwr_pkg::ST_ADDR_ACK;
              rw_q <= shift_q[0];
              sda_oe_o <= 1'b1;
            end else if (byte_in) begin
              st_q <= pwr_pkg::ST_SKIP;
            end
          end
          pwr_pkg::ST_ADDR_ACK: begin
            cnt_q <= 4'h0;
            ptr_phase_q <= !rw_q;
            st_q <= rw_q ? pwr_pkg::ST_RD : pwr_pkg::ST_WR;
            sda_oe_o <= rw_q && !rd_byte[7];
          end
          pwr_pkg::ST_WR: begin
            if (byte_in) begin
              st_q <= pwr_pkg::ST_WR_ACK;
              sda_oe_o <= 1'b1;
            end
          end
          pwr_pkg::ST_WR_ACK: begin
            st_q <= pwr_pkg::ST_WR;
            cnt_q <= 4'h0;
            ptr_phase_q <= 1'b0;
            sda_oe_o <= 1'b0;
          end
          pwr_pkg::ST_RD: begin
            if (byte_in) begin
              st_q <= pwr_pkg::ST_RD_ACK;
              sda_oe_o <= 1'b0;
            end else begin
              sda_oe_o <= !rd_bit;
            end
          end
          pwr_pkg::ST_RD_ACK: begin
            // A not-acknowledge ends the read until the next start
            cnt_q <= 4'h0;
            st_q <= nack_q ? pwr_pkg::ST_SKIP : pwr_pkg::ST_RD;
            sda_oe_o <= !nack_q && !rd_byte[7];
          end
          default: sda_oe_o <= 1'b0;
        endcase
      end
    end
  end

  // Register pointer: first written byte loads it, data bytes step it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_q <= 8'h00;
    end else if (ce_i) begin
      if (wr_byte && ptr_phase_q) begin
        ptr_q <= shift_q;
      end else if (wr_byte || rd_done) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // Settings; bus writes and flash restore share one port
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_addr_q <= pwr_pkg::BUS_ADDR_RST;
      lamp_mode_q <= pwr_pkg::LAMP_MODE_RST;
      pad_measure_cycle_count_o <= pwr_pkg::CYCLES_RST;
      threshold_q <= pwr_pkg::THRESHOLD_RST;
      hysteresis_q <= pwr_pkg::HYSTERESIS_RST;
      osc_range_trim_o <= pwr_pkg::OSC_TRIM_RST;
      osc_mod_trim_o <= pwr_pkg::OSC_TRIM_RST;
    end else if (ce_i && reg_we) begin
      case (wr_ofs)
        pwr_pkg::OFS_BUS_ADDR: bus_addr_q <= wr_dat[6:0];
        pwr_pkg::OFS_LAMP_MODE: lamp_mode_q <= wr_dat;
        pwr_pkg::OFS_CYCLES: pad_measure_cycle_count_o <= wr_dat;
        pwr_pkg::OFS_THRESHOLD: threshold_q <= wr_dat;
        pwr_pkg::OFS_HYSTERESIS: hysteresis_q <= wr_dat;
        pwr_pkg::OFS_OSC_RANGE: osc_range_trim_o <= wr_dat;
        pwr_pkg::OFS_OSC_MOD: osc_mod_trim_o <= wr_dat;
        default: ;
      endcase
    end
  end

  // Save changed settings; restore comes back on nvm_load_i
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nvm_wr_o <= 1'b0;
      nvm_addr_o <= 8'h00;
      nvm_data_o <= 8'h00;
      sda_o <= 1'b0;
    end else if (ce_i) begin
      nvm_wr_o <= bus_wr && is_persist(ptr_q);
      nvm_addr_o <= ptr_q;
      nvm_data_o <= shift_q;
      sda_o <= 1'b0;
    end
  end

  // Freeze the battery value during a read so both bytes match
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vbat_snap_q <= 10'h000;
    end else if (ce_i && !in_read) begin
      vbat_snap_q <= vbat_i;
    end
  end

  // Touch detection and history
  pad_touch_detect u_touch (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .sample_i(pad_sample_i),
    .reading_i(pad_reading_i),
    .threshold_i(threshold_q),
    .hysteresis_i(hysteresis_q),
    .touched_o(touched),
    .history_o(history)
  );

  // Press-and-hold counter; short touches only reach the history
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_cnt_q <= 8'h00;
      host_off_req_o <= 1'b0;
    end else if (ce_i) begin
      host_off_req_o <= pad_sample_i && touched
        && (hold_cnt_q == pwr_pkg::HOLD_SAMPLES - 8'h01)
        && (host_state_i == pwr_pkg::HOST_ON);
      if (pad_sample_i && !touched) begin
        hold_cnt_q <= 8'h00;
      end else if (pad_sample_i && hold_cnt_q != pwr_pkg::HOLD_SAMPLES) begin
        hold_cnt_q <= hold_cnt_q + 8'h01;
      end
    end
  end

  // Lamp timebase: PWM ramp for pulsing, toggle for fast flash
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwm_q <= 8'h00;
      level_q <= 8'h00;
      dir_q <= 1'b0;
      flash_q <= 1'b0;
      step_cnt_q <= '0;
      flash_cnt_q <= '0;
    end else if (ce_i) begin
      pwm_q <= pwm_q + 8'h01;
      step_cnt_q <= step_cnt_q + 1'b1;
      flash_cnt_q <= flash_cnt_q + 1'b1;
      if (step_cnt_q == pwr_pkg::CNT_W'(PULSE_STEP_CYC - 1)) begin
        step_cnt_q <= '0;
        level_q <= dir_q ? level_q - 8'h01 : level_q + 8'h01;
        if ((dir_q && level_q == 8'h01) || (!dir_q && level_q == 8'hFE)) begin
          dir_q <= !dir_q;
        end
      end
      if (flash_cnt_q == pwr_pkg::CNT_W'(FLASH_HALF_CYC - 1)) begin
        flash_cnt_q <= '0;
        flash_q <= !flash_q;
      end
    end
  end

  // Lamp selection by host state, then by mode
  wire pulse_on = (pwm_q < level_q);
  wire mode_on =
    (lamp_mode_q == pwr_pkg::LAMP_OFF) ? 1'b0 :
    (lamp_mode_q == pwr_pkg::LAMP_PULSE) ? pulse_on :
    (lamp_mode_q == pwr_pkg::LAMP_FLASH) ? flash_q : 1'b1;
  wire lamp_d =
    (host_state_i == pwr_pkg::HOST_OFF) ? 1'b0 :
    (host_state_i == pwr_pkg::HOST_ON) ? mode_on : pulse_on;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_lamp_o <= 1'b0;
    end else if (ce_i) begin
      power_lamp_o <= lamp_d;
    end
  end

  property p_addr_ack;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && scl_fall && st_q == pwr_pkg::ST_ADDR && byte_in && addr_hit
    |=> sda_oe_o && st_q == pwr_pkg::ST_ADDR_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("no address ack");

  property p_addr_miss;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && scl_fall && st_q == pwr_pkg::ST_ADDR && byte_in && !addr_hit
    |=> !sda_oe_o && st_q == pwr_pkg::ST_SKIP;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign ack");

  property p_version;
    @(posedge clk_i) disable iff (!resetn_i)
    ptr_q == pwr_pkg::OFS_VERSION |-> rd_byte == 8'h03;
  endproperty
  a_version: assert property (p_version)
    else $error("bad version");

  property p_lamp_dark;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && host_state_i == pwr_pkg::HOST_OFF |=> !power_lamp_o;
  endproperty
  a_lamp_dark: assert property (p_lamp_dark)
    else $error("lamp lit");

  property p_lamp_on;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && host_state_i == pwr_pkg::HOST_ON && lamp_mode_q == 8'h01
    |=> power_lamp_o;
  endproperty
  a_lamp_on: assert property (p_lamp_on)
    else $error("lamp not on");

  property p_ptr_step;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && (bus_wr || rd_done) |=> ptr_q == $past(ptr_q) + 8'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer stuck");

  property p_host_off;
    @(posedge clk_i) disable iff (!resetn_i)
    host_off_req_o |-> $past(hold_cnt_q) == 8'h07 ##1 !host_off_req_o;
  endproperty
  a_host_off: assert property (p_host_off)
    else $error("bad off request");

  property p_nvm_save;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && bus_wr && is_persist(ptr_q)
    |=> nvm_wr_o && nvm_addr_o == $past(ptr_q) && nvm_data_o == $past(shift_q);
  endproperty
  a_nvm_save: assert property (p_nvm_save)
    else $error("save missed");

endmodule

// ### test/i2c_host_model.sv
// Bus controller model: drives SCL and pulls SDA low, open drain.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
`timescale 1ns/10ps
module i2c_host_model (
  // Pins
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Idle bus: SCL stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // One bit; SDA moves only while SCL is low
  task automatic bit_io(input logic b, output logic s);
    sda_low_o = !b;
    #95 scl_o = 1'b1;
    #50 s = sda_i;
    #50 scl_o = 1'b0;
    #5;
  endtask
  // Start, also used as repeated start
  task automatic start();
    sda_low_o = 1'b0;
    #95 scl_o = 1'b1;
    #100 sda_low_o = 1'b1;
    #100 scl_o = 1'b0;
    #5;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    #95 scl_o = 1'b1;
    #100 sda_low_o = 1'b0;
    #100;
  endtask
  // Byte out and in at once; sending FF releases SDA for a read
  task automatic xfer(input logic [7:0] d, input logic ai,
                      output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, ak);
  endtask
endmodule

// ### test/test_touch_power_i2c_regs.sv
// Self-checking bench for the power manager register bank.
// Assumes the bus model above and shortened lamp timing parameters.
`timescale 1ns/10ps
module test_touch_power_i2c_regs;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [1:0] host_state_i = 2'b00;
  logic pad_sample_i = 1'b0;
  logic [15:0] pad_reading_i = 16'h0000;
  logic [9:0] vbat_i = 10'h000;
  logic nvm_load_i = 1'b0;
  logic [7:0] nvm_addr_i = 8'h00;
  logic [7:0] nvm_data_i = 8'h00;
  logic scl, sda_low, sda_o, sda_oe_o, lamp, off_req, nvm_wr;
  logic [7:0] cyc_o, rng_o, mod_o, nvm_a, nvm_d;
  logic [7:0] q [8];
  logic [3:0] hist = 4'h0;
  logic [15:0] nvm_last = 16'h0000;
  logic tch = 1'b0;
  logic prim = 1'b1;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'hf723;
  int offs = 0;
  int wrs = 0;
  int base = 0;
  int thr = 12;
  int tofs [4] = '{14, 15, 10, 9};
  // Pull-up wire: low when either side pulls
  wire sda = !(sda_low || sda_oe_o);
  always #12.5 clk_i = ~clk_i;
  touch_power_i2c_regs #(.PULSE_STEP_CYC(4), .FLASH_HALF_CYC(8)) uut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .host_state_i(host_state_i), .power_lamp_o(lamp),
    .host_off_req_o(off_req), .pad_sample_i(pad_sample_i),
    .pad_reading_i(pad_reading_i), .pad_measure_cycle_count_o(cyc_o),
    .vbat_i(vbat_i), .osc_range_trim_o(rng_o), .osc_mod_trim_o(mod_o),
    .nvm_load_i(nvm_load_i), .nvm_addr_i(nvm_addr_i),
    .nvm_data_i(nvm_data_i), .nvm_wr_o(nvm_wr), .nvm_addr_o(nvm_a),
    .nvm_data_o(nvm_d));
  i2c_host_model h (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  // Count one-cycle pulses of shutdown request and flash save
  always @(posedge clk_i) begin
    if (off_req === 1'b1) offs++;
    if (nvm_wr === 1'b1) begin
      wrs++;
      nvm_last = {nvm_a, nvm_d};
    end
  end
  task automatic results();
    $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write n bytes of q from pointer p; ak is the address acknowledge
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input int n, output logic ak);
    logic [7:0] x;
    logic k;
    h.start();
    h.xfer({a, 1'b0}, 1'b1, x, ak);
    h.xfer(p, 1'b1, x, k);
    for (int i = 0; i < n; i++)
      h.xfer(q[i], 1'b1, x, k);
    h.stop();
  endtask
  // Set pointer, repeated start, read n bytes into q, NACK the last
  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    input int n, output logic ak);
    logic [7:0] x;
    logic k;
    h.start();
    h.xfer({a, 1'b0}, 1'b1, x, ak);
    h.xfer(p, 1'b1, x, k);
    h.start();
    h.xfer({a, 1'b1}, 1'b1, x, k);
    for (int i = 0; i < n; i++)
      h.xfer(8'hFF, i == n - 1, q[i], k);
    h.stop();
  endtask
  // Lamp kind over 2048 cycles: 0 dark, 1 lit, 2 both levels seen
  task automatic lampchk(input int kind);
    int hi;
    hi = 0;
    repeat (4) @(posedge clk_i);
    repeat (2048) begin
      @(posedge clk_i);
      hi += (lamp === 1'b1);
    end
    chk(kind == 0 ? hi == 0 : kind == 1 ? hi == 2048 : hi > 0 && hi < 2048,
        1);
  endtask
  // One touch sample plus the expected decision and baseline
  task automatic smp(input int r);
    logic t;
    @(posedge clk_i);
    pad_reading_i <= r[15:0];
    pad_sample_i <= 1'b1;
    @(posedge clk_i);
    pad_sample_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    if (prim) begin
      base = r;
      prim = 1'b0;
    end else begin
      t = tch ? r >= base + thr - 2 : r > base + thr + 2;
      // Baseline follows whenever the previous decision was untouched
      if (!tch) base = base + ((r - base) >>> 4);
      hist = {hist[2:0], t};
      tch = t;
    end
  endtask
  task automatic hchk();
    logic k;
    rd(7'h43, 8'h1D, 1, k);
    chk(q[0], {4'h0, hist});
  endtask
  // Hang guard
  initial begin
    #1500000;
    fail_count++;
    results();
  end
  initial begin
    logic k;
    int w;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(cyc_o, 8'h14);
    chk(lamp, 1'b0);
    rd(7'h43, 8'h00, 8, k);
    chk(k, 1'b0);
    chk(sda_o, 1'b0);
    chk(q[0], 8'h03);
    chk({q[1], q[2]}, 16'h4301);
    chk({q[3], q[4], q[5]}, 24'h140C02);
    chk({q[6], q[7]}, 16'h0000);
    rd(7'h44, 8'h00, 1, k);
    chk(k, 1'b1);
    q[0] = 8'h55;
    w = wrs;
    wr(7'h43, 8'h00, 1, k);
    rd(7'h43, 8'h00, 1, k);
    chk({q[0], 8'(wrs - w)}, 16'h0300);
    q[0] = 8'($random(seed));
    q[1] = 8'($random(seed));
    wr(7'h43, 8'h06, 2, k);
    chk({rng_o, mod_o}, {q[0], q[1]});
    chk(24'(wrs - w), 24'h000002);
    chk(nvm_last, {8'h07, q[1]});
    @(posedge clk_i);
    host_state_i <= 2'b10;
    for (int m = 0; m < 4; m++) begin
      q[0] = m[7:0];
      wr(7'h43, 8'h02, 1, k);
      lampchk(m == 0 ? 0 : m == 1 ? 1 : 2);
    end
    for (int s = 0; s < 4; s++) begin
      host_state_i <= s[1:0];
      lampchk(s == 0 ? 0 : 2);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      vbat_i <= i ? 10'($random(seed)) : 10'h3FF;
      @(posedge clk_i);
      rd(7'h43, 8'h19, 2, k);
      chk({q[1], q[0]}, {6'h00, vbat_i});
    end
    @(posedge clk_i);
    host_state_i <= 2'b10;
    thr = 48;
    q[0] = 8'h30;
    wr(7'h43, 8'h04, 1, k);
    for (int i = 0; i < 24; i++)
      smp(i < 4 ? 100 : base + 16 + ($random(seed) & 31));
    hchk();
    thr = 12;
    q[0] = 8'h0C;
    wr(7'h43, 8'h04, 1, k);
    for (int i = 0; i < 4; i++)
      smp(base + tofs[i]);
    hchk();
    chk(24'(offs), 24'h000000);
    repeat (10) smp(base + 15);
    hchk();
    chk(24'(offs), 24'h000001);
    @(posedge clk_i);
    nvm_addr_i <= 8'h03;
    nvm_data_i <= 8'h33;
    nvm_load_i <= 1'b1;
    @(posedge clk_i);
    nvm_load_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(cyc_o, 8'h33);
    q[0] = 8'h2A;
    wr(7'h43, 8'h01, 1, k);
    rd(7'h2A, 8'h00, 1, k);
    chk({k, q[0]}, 9'h003);
    rd(7'h43, 8'h00, 1, k);
    chk(k, 1'b1);
    results();
  end
endmodule
